// File: verilog/tcpwm_pkg.sv
// package for the three-phase complementary pwm block: register map, field positions, reset values, bus carriers
// assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data
package tcpwm_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_UPPER_CNT = 8'h08;
  localparam logic [7:0] OFS_LOWER_CNT = 8'h0C;
  localparam logic [7:0] OFS_DEAD_TIME = 8'h10;
  localparam logic [7:0] OFS_CARRIER_CMP = 8'h14;
  localparam logic [7:0] OFS_CARRIER_BUF = 8'h18;
  localparam logic [7:0] OFS_HALF_CMP = 8'h1C;
  localparam logic [7:0] OFS_HALF_BUF = 8'h20;
  localparam logic [7:0] OFS_DUTY_CMP [3] = '{8'h24, 8'h28, 8'h2C};
  localparam logic [7:0] OFS_DUTY_BUF [3] = '{8'h30, 8'h34, 8'h38};
  localparam logic [7:0] OFS_PIN_STATE = 8'h3C;
  localparam logic [5:0] LAST_WORD_INDEX = 6'h0F;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_SYNC_BIT = 8;
  localparam logic [3:0] MODE_COMPLEMENTARY = 4'hF;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam int unsigned STAT_MATCH_BIT = 0;
  localparam int unsigned STAT_UPPER_UP_BIT = 1;
  localparam int unsigned STAT_LOWER_UP_BIT = 2;
  localparam int unsigned STAT_PENDING_BIT = 3;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } tcpwm_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } tcpwm_axi_rsp_t;

  // pin order: bit 0 phase u, bit 1 phase v, bit 2 phase w
  typedef struct packed {
    logic syncToggle;
    logic [2:0] positive;
    logic [2:0] negative;
  } tcpwm_pins_t;

endpackage

// File: verilog/tcpwm_three_phase_pwm.sv
// three-phase complementary pwm generator with dead time and a period-synchronous toggle output
// assumes one AXI4-Lite master on sys_clk and gate drivers that take the pin levels as they are
//
// Overview of operation
// R1: upper counter reverses at half-period and dead-time
// R2: lower counter reverses at carrier half-period, zero
// R3: software read/write dead-time register sets dead time
// R4: read/write carrier half-period register bounds lower counter
// R5: carrier buffer copied into carrier register while running
// R6: half-period compare changed at runtime via buffer
// R7: half-period buffer copied into compare while running
// R8: phase u buffer passes first temporary then compare
// R9: three temporary stages, invisible to software
// R10: phase v, w buffers pass to compares
// R11: three complementary pairs with dead time, zero allowed
// R12: lower count equal dead time forces negatives low
// R13: phase w outputs invert on counter matches
// R14: phase v outputs invert on counter matches
// R15: phase u outputs invert on counter matches
// R16: upper half-period match raises interrupt request
// R17: software writes phase w buffer last, always
// R18: software preloads counters before start
// R19: software changes duty only through buffers
// R20: toggle output gives fixed half-duty square wave
// R21: any duty from fully off to fully on
// R22: runs only when mode field is all ones
// R23: toggle output only when its enable is set
// R24: software sets half-period as carrier plus dead
// R25: phase w write arms transfer, applied at turn
// R26: zero dead time switches pairs on same cycle
//
// The address map and the AXI4-Lite slave port were decided locally.
module tcpwm_three_phase_pwm
  import tcpwm_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register bus
  input wire tcpwm_axi_req_t axiReq,
  output tcpwm_axi_rsp_t axiRsp,
  // power stage and events
  output tcpwm_pins_t pins,
  output logic compareMatchIrq
);

  // ************************************************************
  // elaboration check
  // ************************************************************
  generate
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("tcpwm_three_phase_pwm: CNT_W must lie in 2..32");
    end
  endgenerate

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [CNT_W-1:0] mergeLanes(input logic [CNT_W-1:0] old, input logic [31:0] data,
                                                  input logic [3:0] strb);
    logic [31:0] word;
    word = 32'(old);
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        word[8*i +: 8] = data[8*i +: 8];
      end
    end
    return word[CNT_W-1:0];
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    return (addr[1:0] == 2'b00) && (addr[7:2] <= LAST_WORD_INDEX);
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic awHave, wHave, awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData, wDataQ, readWord;
  logic [3:0] wStrbQ;
  logic [ADDR_W-1:0] awAddrQ;
  logic next_awHave, next_wHave, next_bValid, next_rValid;
  logic wrFire, arTaken;
  logic ctrlRun, syncEnable;
  logic [3:0] ctrlMode;
  logic [CNT_W-1:0] upper, lower, deadTime, carrierCmp, carrierBuf, halfCmp, halfBuf;
  logic [CNT_W-1:0] dutyCmp [3];
  logic [CNT_W-1:0] dutyBuf [3];
  logic [CNT_W-1:0] dutyTemp [3];
  logic upperUp, lowerUp, tempPending, matchFlag, irqQ;
  logic [2:0] posQ, negQ;
  logic toggleQ;
  logic running, upPeak, upTrough, lowPeak, lowTrough, turnPoint;

  assign axiRsp = '{awready: awReady, wready: wReady, bresp: bResp, bvalid: bValid, arready: arReady,
                    rdata: rData, rresp: rResp, rvalid: rValid};
  assign pins = '{syncToggle: toggleQ, positive: posQ, negative: negQ};
  assign compareMatchIrq = irqQ;

  // ************************************************************
  // bus slave
  // ************************************************************
  assign wrFire = awHave && wHave && !bValid;
  assign arTaken = axiReq.arvalid && arReady;

  always_comb begin
    next_awHave = awHave;
    next_wHave = wHave;
    next_bValid = bValid;
    next_rValid = rValid;
    if (axiReq.awvalid && awReady) begin
      next_awHave = 1'b1;
    end else if (wrFire) begin
      next_awHave = 1'b0;
    end
    if (axiReq.wvalid && wReady) begin
      next_wHave = 1'b1;
    end else if (wrFire) begin
      next_wHave = 1'b0;
    end
    if (wrFire) begin
      next_bValid = 1'b1;
    end else if (bValid && axiReq.bready) begin
      next_bValid = 1'b0;
    end
    if (arTaken) begin
      next_rValid = 1'b1;
    end else if (rValid && axiReq.rready) begin
      next_rValid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awReady <= 1'b0;
      wReady <= 1'b0;
      bValid <= 1'b0;
      bResp <= RESP_OKAY;
      awAddrQ <= '0;
      wDataQ <= WORD_RESET;
      wStrbQ <= '0;
    end else begin
      awHave <= next_awHave;
      wHave <= next_wHave;
      awReady <= !next_awHave && !next_bValid;
      wReady <= !next_wHave && !next_bValid;
      bValid <= next_bValid;
      if (axiReq.awvalid && awReady) begin
        awAddrQ <= axiReq.awaddr;
      end
      if (axiReq.wvalid && wReady) begin
        wDataQ <= axiReq.wdata;
        wStrbQ <= axiReq.wstrb;
      end
      if (wrFire) begin
        bResp <= isMapped(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // temporaries have no address on purpose [R9]
  always_comb begin
    readWord = WORD_RESET;
    unique case (axiReq.araddr)
      OFS_CONTROL: begin
        readWord[CTRL_RUN_BIT] = ctrlRun;
        readWord[CTRL_MODE_LSB +: 4] = ctrlMode;
        readWord[CTRL_SYNC_BIT] = syncEnable;
      end
      OFS_STATUS: begin
        readWord[STAT_MATCH_BIT] = matchFlag;
        readWord[STAT_UPPER_UP_BIT] = upperUp;
        readWord[STAT_LOWER_UP_BIT] = lowerUp;
        readWord[STAT_PENDING_BIT] = tempPending;
      end
      OFS_UPPER_CNT: readWord = 32'(upper);
      OFS_LOWER_CNT: readWord = 32'(lower);
      OFS_DEAD_TIME: readWord = 32'(deadTime); // [R3]
      OFS_CARRIER_CMP: readWord = 32'(carrierCmp); // [R4]
      OFS_CARRIER_BUF: readWord = 32'(carrierBuf);
      OFS_HALF_CMP: readWord = 32'(halfCmp);
      OFS_HALF_BUF: readWord = 32'(halfBuf);
      OFS_DUTY_CMP[0]: readWord = 32'(dutyCmp[0]);
      OFS_DUTY_CMP[1]: readWord = 32'(dutyCmp[1]);
      OFS_DUTY_CMP[2]: readWord = 32'(dutyCmp[2]);
      OFS_DUTY_BUF[0]: readWord = 32'(dutyBuf[0]);
      OFS_DUTY_BUF[1]: readWord = 32'(dutyBuf[1]);
      OFS_DUTY_BUF[2]: readWord = 32'(dutyBuf[2]);
      OFS_PIN_STATE: readWord = 32'({toggleQ, posQ, negQ});
      default: readWord = WORD_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arReady <= 1'b0;
      rValid <= 1'b0;
      rData <= WORD_RESET;
      rResp <= RESP_OKAY;
    end else begin
      arReady <= !next_rValid;
      rValid <= next_rValid;
      if (arTaken) begin
        rData <= readWord;
        rResp <= isMapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ************************************************************
  // counters
  // ************************************************************
  assign running = ctrlRun && (ctrlMode == MODE_COMPLEMENTARY); // [R22]
  assign upPeak = running && upperUp && (upper == halfCmp);
  assign upTrough = running && !upperUp && (upper == deadTime);
  assign lowPeak = running && lowerUp && (lower == carrierCmp);
  assign lowTrough = running && !lowerUp && (lower == '0);
  assign turnPoint = upPeak || lowTrough;

  // a software load restarts the count upward so the preload sequence works from any state
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      upper <= '0;
      upperUp <= 1'b1;
    end else if (wrFire && awAddrQ == OFS_UPPER_CNT) begin
      upper <= mergeLanes(upper, wDataQ, wStrbQ);
      upperUp <= 1'b1;
    end else if (upPeak) begin
      upperUp <= 1'b0; // [R1]
      upper <= upper - 1'b1;
    end else if (upTrough) begin
      upperUp <= 1'b1; // [R1]
      upper <= upper + 1'b1;
    end else if (running) begin
      upper <= upperUp ? upper + 1'b1 : upper - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lower <= '0;
      lowerUp <= 1'b1;
    end else if (wrFire && awAddrQ == OFS_LOWER_CNT) begin
      lower <= mergeLanes(lower, wDataQ, wStrbQ);
      lowerUp <= 1'b1;
    end else if (lowPeak) begin
      lowerUp <= 1'b0; // [R2]
      lower <= lower - 1'b1;
    end else if (lowTrough) begin
      lowerUp <= 1'b1; // [R2]
      lower <= lower + 1'b1;
    end else if (running) begin
      lower <= lowerUp ? lower + 1'b1 : lower - 1'b1;
    end
  end

  // ************************************************************
  // configuration, buffers and temporary stages
  // ************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlRun <= 1'b0;
      ctrlMode <= MODE_RESET;
      syncEnable <= 1'b0;
      deadTime <= '0;
      carrierCmp <= '0;
      carrierBuf <= '0;
      halfCmp <= '0;
      halfBuf <= '0;
      tempPending <= 1'b0;
      for (int p = 0; p < 3; p++) begin
        dutyCmp[p] <= '0;
        dutyBuf[p] <= '0;
        dutyTemp[p] <= '0;
      end
    end else begin
      if (turnPoint) begin
        carrierCmp <= carrierBuf; // [R5]
        halfCmp <= halfBuf; // [R7]
        if (tempPending) begin
          for (int p = 0; p < 3; p++) begin
            dutyCmp[p] <= dutyTemp[p]; // [R8] [R10] [R25]
          end
          tempPending <= 1'b0;
        end
      end
      if (wrFire) begin
        unique case (awAddrQ)
          OFS_CONTROL: begin
            if (wStrbQ[0]) begin
              ctrlRun <= wDataQ[CTRL_RUN_BIT];
              ctrlMode <= wDataQ[CTRL_MODE_LSB +: 4];
            end
            if (wStrbQ[1]) begin
              syncEnable <= wDataQ[CTRL_SYNC_BIT];
            end
          end
          OFS_DEAD_TIME: deadTime <= mergeLanes(deadTime, wDataQ, wStrbQ); // [R3]
          OFS_CARRIER_CMP: carrierCmp <= mergeLanes(carrierCmp, wDataQ, wStrbQ); // [R4]
          OFS_CARRIER_BUF: carrierBuf <= mergeLanes(carrierBuf, wDataQ, wStrbQ);
          OFS_HALF_CMP: halfCmp <= mergeLanes(halfCmp, wDataQ, wStrbQ);
          OFS_HALF_BUF: halfBuf <= mergeLanes(halfBuf, wDataQ, wStrbQ); // [R6]
          OFS_DUTY_CMP[0]: dutyCmp[0] <= mergeLanes(dutyCmp[0], wDataQ, wStrbQ);
          OFS_DUTY_CMP[1]: dutyCmp[1] <= mergeLanes(dutyCmp[1], wDataQ, wStrbQ);
          OFS_DUTY_CMP[2]: dutyCmp[2] <= mergeLanes(dutyCmp[2], wDataQ, wStrbQ);
          OFS_DUTY_BUF[0]: dutyBuf[0] <= mergeLanes(dutyBuf[0], wDataQ, wStrbQ);
          OFS_DUTY_BUF[1]: dutyBuf[1] <= mergeLanes(dutyBuf[1], wDataQ, wStrbQ);
          OFS_DUTY_BUF[2]: begin
            // the phase w write commits the whole set; set wins over a same-cycle apply
            dutyBuf[2] <= mergeLanes(dutyBuf[2], wDataQ, wStrbQ);
            dutyTemp[0] <= dutyBuf[0]; // [R8]
            dutyTemp[1] <= dutyBuf[1]; // [R10]
            dutyTemp[2] <= mergeLanes(dutyBuf[2], wDataQ, wStrbQ); // [R25]
            tempPending <= 1'b1; // [R25]
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // compare-match event
  // ************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      matchFlag <= 1'b0;
      irqQ <= 1'b0;
    end else begin
      irqQ <= upPeak; // [R16]
      if (upPeak) begin
        matchFlag <= 1'b1; // [R16]
      end else if (wrFire && awAddrQ == OFS_STATUS && wStrbQ[0] && wDataQ[STAT_MATCH_BIT]) begin
        matchFlag <= 1'b0;
      end
    end
  end

  // ************************************************************
  // output pairs and toggle
  // ************************************************************
  // a duty value outside the counting range never matches, which holds a pair fully on or off
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      posQ <= '0;
      negQ <= '0;
    end else if (running) begin
      for (int p = 0; p < 3; p++) begin
        if (lower == deadTime) begin
          negQ[p] <= 1'b0; // [R12] [R26]
        end else if (upper == dutyCmp[p]) begin
          negQ[p] <= !negQ[p]; // [R11] [R13] [R14] [R15] [R21]
        end
        if (lower == dutyCmp[p]) begin
          posQ[p] <= !posQ[p]; // [R11] [R13] [R14] [R15] [R21]
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      toggleQ <= 1'b0;
    end else if (!syncEnable) begin
      toggleQ <= 1'b0; // [R23]
    end else if (upPeak || upTrough) begin
      toggleQ <= !toggleQ; // [R20]
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_upper_turn_down: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
    upPeak && !(wrFire && awAddrQ == OFS_UPPER_CNT) |=> !upperUp && upper == $past(halfCmp) - 1'b1)
    else $error("upper counter did not turn down at half period");
  a_lower_turn_up: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
    lowTrough && !(wrFire && awAddrQ == OFS_LOWER_CNT) |=> lowerUp && lower == 1)
    else $error("lower counter did not turn up at zero");
  a_neg_forced_low: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R12]
    running && lower == deadTime |=> negQ == 3'b000)
    else $error("negative outputs not forced low");
  a_pos_w_invert: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R13]
    running && lower == dutyCmp[2] |=> posQ[2] != $past(posQ[2]))
    else $error("phase w positive did not invert");
  a_neg_u_invert: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R15]
    running && lower != deadTime && upper == dutyCmp[0] |=> negQ[0] != $past(negQ[0]))
    else $error("phase u negative did not invert");
  a_irq_on_peak: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R16]
    upPeak |=> irqQ ##1 !irqQ || $past(upPeak))
    else $error("interrupt pulse missing or too long");
  a_w_write_arms: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R25]
    wrFire && awAddrQ == OFS_DUTY_BUF[2] |=> tempPending && dutyTemp[0] == $past(dutyBuf[0]))
    else $error("phase w write did not arm the temporary stages");
  a_temp_applied: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R8]
    turnPoint && tempPending && !wrFire |=> dutyCmp[0] == $past(dutyTemp[0]) && !tempPending)
    else $error("temporary stage not applied at turning point");
  a_toggle_disabled: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R23]
    !syncEnable |=> !toggleQ)
    else $error("toggle output active while disabled");
  a_mode_gates_run: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R22]
    ctrlMode != MODE_COMPLEMENTARY && !wrFire |=> $stable(upper) && $stable(lower))
    else $error("counters moved outside complementary mode");
  a_carrier_copy: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R5]
    turnPoint && !wrFire |=> carrierCmp == $past(carrierBuf) && halfCmp == $past(halfBuf))
    else $error("cycle buffers not copied at turning point");
  a_write_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wrFire |=> bValid ##0 !awReady && !wReady)
    else $error("write response not given one cycle after both parts");

endmodule // tcpwm_three_phase_pwm

// File: tb/tcpwm_gate_driver_model.sv
// gate driver model: takes the pin levels and counts level changes per pin
// assumes registered pins that settle between sys_clk edges
module tcpwm_gate_driver_model
  import tcpwm_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // power stage inputs
  input wire tcpwm_pins_t pins,
  // switching statistics, index = pin bit
  output logic [15:0] switchCount [7]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] lastLevel;
  // counting every edge lets the bench judge switching rate without timing guesses
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastLevel <= 7'h00;
      for (int i = 0; i < 7; i++) begin
        switchCount[i] <= 16'h0000;
      end
    end else begin
      lastLevel <= pins;
      for (int i = 0; i < 7; i++) begin
        if (pins[i] != lastLevel[i]) switchCount[i] <= switchCount[i] + 16'h0001;
      end
    end
  end
endmodule // tcpwm_gate_driver_model

// File: tb/test_three_phase_complementary_pwm.sv
// self-checking bench for the three-phase pwm block
// assumes the design package and a gate driver model on the pins
module test_three_phase_complementary_pwm
  import tcpwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic sys_rst;
  tcpwm_axi_req_t axiReq;
  tcpwm_axi_rsp_t axiRsp;
  tcpwm_pins_t pins;
  logic compareMatchIrq;
  logic [15:0] switchCount [7];
  logic [15:0] countBase [7];
  logic [31:0] rdData;
  logic [31:0] toggleHigh;
  logic [1:0] lastResp;
  int mismatches;
  int samples_checked;

  tcpwm_three_phase_pwm #(.CNT_W(16)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .axiReq(axiReq),
    .axiRsp(axiRsp), .pins(pins), .compareMatchIrq(compareMatchIrq));
  tcpwm_gate_driver_model driver (.sys_clk(sys_clk), .sys_rst(sys_rst), .pins(pins),
    .switchCount(switchCount));

  // ************************************************************
  // bus and compare helpers
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  // waits for the answer however long it takes; only the watchdog ends a hang
  task automatic axiWrite(input logic [7:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    axiReq.awaddr <= addr;
    axiReq.awvalid <= 1'h1;
    axiReq.wdata <= data;
    axiReq.wstrb <= 4'hF;
    axiReq.wvalid <= 1'h1;
    axiReq.bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'h0;
      if (axiRsp.wready) axiReq.wvalid <= 1'h0;
    end while (axiRsp.bvalid !== 1'h1);
    lastResp = axiRsp.bresp;
    axiReq.bready <= 1'h0;
  endtask

  task automatic rdCheck(input logic [7:0] addr, input logic [31:0] expected);
    @(posedge sys_clk);
    axiReq.araddr <= addr;
    axiReq.arvalid <= 1'h1;
    axiReq.rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'h0;
    end while (axiRsp.rvalid !== 1'h1);
    rdData = axiRsp.rdata;
    lastResp = axiRsp.rresp;
    axiReq.rready <= 1'h0;
    check(rdData, expected);
  endtask

  // edges and toggle-high cycles over a window of whole cycles
  task automatic measureWindow(input int cycles);
    countBase = switchCount;
    toggleHigh = 32'h0000_0000;
    repeat (cycles) begin
      @(posedge sys_clk);
      toggleHigh += {31'h0000_0000, pins.syncToggle};
    end
  endtask

  function automatic logic [31:0] edges(input int i);
    return {16'h0000, switchCount[i] - countBase[i]};
  endfunction

  task automatic irqGap(input logic [31:0] expected);
    logic [31:0] n;
    n = 32'h0000_0000;
    @(posedge sys_clk iff compareMatchIrq === 1'h1);
    do begin
      @(posedge sys_clk);
      n++;
    end while (compareMatchIrq !== 1'h1 && n < 32'h0000_0064);
    check(n, expected);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic testRegisterMap();
    rdCheck(OFS_CONTROL, WORD_RESET);
    axiWrite(OFS_DEAD_TIME, 32'hFFFF_BEEF);
    rdCheck(OFS_DEAD_TIME, 32'h0000_BEEF);
    axiWrite(OFS_CARRIER_CMP, 32'h0000_1234);
    rdCheck(OFS_CARRIER_CMP, 32'h0000_1234);
    axiWrite(8'h40, 32'h0000_0001);
    check({30'h0000_0000, lastResp}, {30'h0000_0000, RESP_SLVERR});
    rdCheck(8'h42, WORD_RESET);
    check({30'h0000_0000, lastResp}, {30'h0000_0000, RESP_SLVERR});
    $display("register map test done");
  endtask

  // mode field left clear: nothing may count or transfer
  task automatic testStopped();
    axiWrite(OFS_UPPER_CNT, 32'h0000_0002);
    axiWrite(OFS_LOWER_CNT, WORD_RESET);
    axiWrite(OFS_CONTROL, 32'h0000_0101);
    repeat (12) @(posedge sys_clk);
    rdCheck(OFS_UPPER_CNT, 32'h0000_0002);
    axiWrite(OFS_DUTY_BUF[0], 32'h0000_0005);
    axiWrite(OFS_DUTY_BUF[1], 32'h0000_0006);
    rdCheck(OFS_STATUS, 32'h0000_0006);
    axiWrite(OFS_DUTY_BUF[2], 32'h0000_0050);
    rdCheck(OFS_STATUS, 32'h0000_000E);
    rdCheck(OFS_DUTY_CMP[0], WORD_RESET);
    $display("stopped test done");
  endtask

  // dead time 2, carrier half 10, half period 12: both counters have a 20-cycle period
  task automatic testRunning();
    axiWrite(OFS_DEAD_TIME, 32'h0000_0002);
    axiWrite(OFS_CARRIER_CMP, 32'h0000_000A);
    axiWrite(OFS_CARRIER_BUF, 32'h0000_000A);
    axiWrite(OFS_HALF_CMP, 32'h0000_000C);
    axiWrite(OFS_HALF_BUF, 32'h0000_000C);
    axiWrite(OFS_CONTROL, 32'h0000_01F1);
    repeat (30) @(posedge sys_clk);
    rdCheck(OFS_DUTY_CMP[0], 32'h0000_0005);
    rdCheck(OFS_DUTY_CMP[1], 32'h0000_0006);
    measureWindow(40);
    check(edges(0), 32'h0000_0004);
    check(edges(3), 32'h0000_0004);
    check(edges(1), 32'h0000_0004);
    check(edges(4), 32'h0000_0004);
    check(edges(2), 32'h0000_0000);
    check(edges(5), 32'h0000_0000);
    check(edges(6), 32'h0000_0004);
    check(toggleHigh, 32'h0000_0014);
    irqGap(32'h0000_0014);
    // phase w brought into range: lower and upper both cross 7 twice a period
    axiWrite(OFS_DUTY_BUF[2], 32'h0000_0007);
    repeat (25) @(posedge sys_clk);
    measureWindow(40);
    check(edges(2), 32'h0000_0004);
    check(edges(5), 32'h0000_0004);
    axiWrite(OFS_CARRIER_BUF, 32'h0000_000C);
    axiWrite(OFS_HALF_BUF, 32'h0000_000E);
    repeat (30) @(posedge sys_clk);
    rdCheck(OFS_CARRIER_CMP, 32'h0000_000C);
    rdCheck(OFS_HALF_CMP, 32'h0000_000E);
    irqGap(32'h0000_0018);
    axiWrite(OFS_CONTROL, 32'h0000_00F1);
    repeat (2) @(posedge sys_clk);
    measureWindow(40);
    check(toggleHigh, 32'h0000_0000);
    $display("running test done");
  endtask

  // ************************************************************
  // clock, reset, sequence and verdict
  // ************************************************************
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end

  initial begin
    axiReq = '0;
    sys_rst = 1'h1;
    mismatches = 0;
    samples_checked = 0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge sys_clk);
    testRegisterMap();
    testStopped();
    testRunning();
    final_report();
  end
endmodule // test_three_phase_complementary_pwm
